/* File: inc/exec_pkg.sv */
// Purpose: shared constants and carrier types for the decode/execute block
// Assumes: 16-bit opcodes, 32-bit operands, one clock domain
// Notes: status word layout and opcode patterns defined here; checker and bench also use literal bit positions and opcodes
package exec_pkg;

  // status word bit positions
  localparam int PSW_TRACE_CTL_HIGH = 15;
  localparam int PSW_TRACE_CTL_LOW  = 14;
  localparam int PSW_SUPER          = 13;
  localparam int PSW_MASK_HI        = 10;
  localparam int PSW_MASK_LO        = 8;
  localparam int PSW_X              = 4;
  localparam int PSW_N              = 3;
  localparam int PSW_Z              = 2;
  localparam int PSW_V              = 1;
  localparam int PSW_C              = 0;
  localparam logic [15:0] PSW_RESET = 16'h2700;

  // opcode patterns
  localparam logic [3:0]  OP_SCC_LINE  = 4'h5;
  localparam logic [1:0]  OP_SCC_SIZE  = 2'h3;
  localparam logic [3:0]  OP_SUB_LINE  = 4'h9;
  localparam logic [15:0] OP_HALT      = 16'h4E72;

  // operation sizes
  localparam logic [1:0] SZ_BYTE = 2'h0;
  localparam logic [1:0] SZ_WORD = 2'h1;
  localparam logic [1:0] SZ_LONG = 2'h2;
  localparam logic [1:0] SZ_NONE = 2'h3;

  // addressing mode codes
  localparam logic [2:0] MODE_DREG  = 3'h0;
  localparam logic [2:0] MODE_AREG  = 3'h1;
  localparam logic [2:0] MODE_IND   = 3'h2;
  localparam logic [2:0] MODE_IDX   = 3'h6;
  localparam logic [2:0] MODE_EXT   = 3'h7;
  localparam logic [2:0] EXT_ABS_L  = 3'h1;
  localparam logic [2:0] EXT_IMM    = 3'h4;

  typedef enum logic [2:0] {
    ST_RESET = 3'h1,
    ST_RUN   = 3'h2,
    ST_HALT  = 3'h4
  } state_t;

  // operand write-back request
  typedef struct packed {
    logic        valid;
    logic        to_ea;
    logic [2:0]  data_reg_sel;
    logic [1:0]  size;
    logic [31:0] data;
  } wb_t;

  // exception requests to the exception unit, one-cycle pulses
  typedef struct packed {
    logic       rst;
    logic       priv_trap;
    logic       illegal;
    logic       trace;
    logic       irq;
    logic [2:0] irq_level;
    logic       pc_advance;
  } exc_t;

endpackage

/* File: rtl/cond_eval.sv */
// Purpose: evaluate a 4-bit condition selector against the flags
// Assumes: flags given as n, z, v, c
// Notes: purely combinational
`timescale 1ns/10ps
module cond_eval
(
  input  wire logic [3:0] sel,
  input  wire logic       n,
  input  wire logic       z,
  input  wire logic       v,
  input  wire logic       c,
  output logic            cond_true
);
  always_comb
  begin
    case (sel)
      4'h0: cond_true = 1'b1;
      4'h1: cond_true = 1'b0;
      4'h2: cond_true = ~c & ~z;
      4'h3: cond_true = c | z;
      4'h4: cond_true = ~c;
      4'h5: cond_true = c;
      4'h6: cond_true = ~z;
      4'h7: cond_true = z;
      4'h8: cond_true = ~v;
      4'h9: cond_true = v;
      4'hA: cond_true = ~n;
      4'hB: cond_true = n;
      4'hC: cond_true = ~(n ^ v);
      4'hD: cond_true = n ^ v;
      4'hE: cond_true = ~(n ^ v) & ~z;
      4'hF: cond_true = z | (n ^ v);
      default: cond_true = 1'b0;
    endcase
  end
endmodule

/* File: rtl/sub_unit.sv */
// Purpose: sized subtract with x n z v c flags
// Assumes: size byte, word or long; upper bits of minuend pass through
// Notes: borrow taken from the extra top bit of a widened difference
`timescale 1ns/10ps
module sub_unit
  import exec_pkg::*;
(
  input  wire logic [1:0]  size,
  input  wire logic [31:0] minuend,
  input  wire logic [31:0] subtrahend,
  output logic [31:0]      diff,
  output logic [4:0]       flags
);
  logic [8:0]  d8;
  logic [16:0] d16;
  logic [32:0] d32;
  logic        msb_a;
  logic        msb_b;
  logic        msb_r;
  logic        zero;
  logic        borrow;

  always_comb
  begin
    d8  = {1'b0, minuend[7:0]} - {1'b0, subtrahend[7:0]};
    d16 = {1'b0, minuend[15:0]} - {1'b0, subtrahend[15:0]};
    d32 = {1'b0, minuend} - {1'b0, subtrahend};
    case (size)
      SZ_BYTE:
      begin
        diff   = {minuend[31:8], d8[7:0]};
        msb_a  = minuend[7];
        msb_b  = subtrahend[7];
        msb_r  = d8[7];
        zero   = (d8[7:0] == 8'h00);
        borrow = d8[8];
      end
      SZ_WORD:
      begin
        diff   = {minuend[31:16], d16[15:0]};
        msb_a  = minuend[15];
        msb_b  = subtrahend[15];
        msb_r  = d16[15];
        zero   = (d16[15:0] == 16'h0000);
        borrow = d16[16];
      end
      default:
      begin
        diff   = d32[31:0];
        msb_a  = minuend[31];
        msb_b  = subtrahend[31];
        msb_r  = d32[31];
        zero   = (d32[31:0] == 32'h00000000);
        borrow = d32[32];
      end
    endcase
    // extend copies carry; overflow when signs differ and result flips
    flags = {borrow, msb_r, zero, (msb_a ^ msb_b) & (msb_a ^ msb_r),
             borrow};
  end
endmodule

/* File: rtl/cond_set_halt_subtract_exec.sv */
// Purpose: decode and execute conditional set, halt and subtract
// Assumes: opcode, extension word and operands arrive together
// Assumes: operands already fetched by the operand path
// Notes: one instruction per cycle; write-back and exceptions registered
// Notes on behaviour
// - conditional set writes all-ones byte if condition true, else zeros.
// - selector codes 0..F map to the sixteen standard flag conditions.
// - selector from opcode bits 11:8; bits 7:6 ones; low six give ea.
// - conditional set destination must be data alterable.
// - supervisor halt loads whole status word, advances pc, stops fetch.
// - halt outside supervisor state traps instead.
// - halted core resumes only on trace, interrupt or reset.
// - trace after halt when tracing enabled as halt begins.
// - halted interrupt taken only above mask of new status word.
// - external reset always starts reset exception, halted or not.
// - halt sets flags from its operand; conditional set keeps them.
// - subtract gives destination minus source at byte, word, long.
// - subtract sets carry, overflow, zero, negative; extend copies carry.
// - opmodes 0-2 data register minus ea; 4-6 ea minus data register.
// - ea as source accepts all modes, no address register for byte.
// - ea as destination accepts only memory alterable modes.
`timescale 1ns/10ps
module cond_set_halt_subtract_exec
  import exec_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rstn,
  input  wire logic        instr_valid,
  input  wire logic [15:0] opcode,
  input  wire logic [15:0] ext_word,
  input  wire logic [31:0] ea_operand,
  input  wire logic [31:0] dreg_operand,
  input  wire logic [2:0]  irq_level,
  output logic             fetch_en,
  output logic [15:0]      processor_state_word,
  output exec_pkg::wb_t    wb,
  output exec_pkg::exc_t   exc
);
  import exec_pkg::*;

  typedef struct packed {
    state_t      st;
    logic [15:0] psw;
    logic        trace_pend;
    logic        fetch_en;
    wb_t         wb;
    exc_t        exc;
  } core_t;

  core_t core_reg;
  core_t core_next;

  // opcode fields
  logic [2:0] ea_mode;
  logic [2:0] ea_reg;
  logic [2:0] sub_opmode;
  logic [1:0] sub_size;
  logic       sub_to_ea;

  // decode results
  logic is_scc;
  logic is_sub;
  logic is_halt;
  logic data_alterable;
  logic mem_alterable;
  logic src_mode_ok;
  logic sub_size_ok;
  logic scc_legal;
  logic sub_legal;
  logic supervisor;
  logic trace_on;
  logic irq_above_mask;

  // execution datapath
  logic        cond_true;
  logic [31:0] sub_minuend;
  logic [31:0] sub_subtrahend;
  logic [31:0] sub_diff;
  logic [4:0]  sub_flags;

  assign ea_mode    = opcode[5:3];
  assign ea_reg     = opcode[2:0];
  assign sub_opmode = opcode[8:6];
  assign sub_size   = sub_opmode[1:0];
  assign sub_to_ea  = sub_opmode[2];

  assign is_scc  = (opcode[15:12] == OP_SCC_LINE)
                 && (opcode[7:6] == OP_SCC_SIZE);
  assign is_sub  = (opcode[15:12] == OP_SUB_LINE);
  assign is_halt = (opcode == OP_HALT);

  // abs short and abs long are the only alterable extended modes
  assign mem_alterable = ((ea_mode >= MODE_IND) && (ea_mode <= MODE_IDX))
                       || ((ea_mode == MODE_EXT) && (ea_reg <= EXT_ABS_L));
  assign data_alterable = mem_alterable
                        || (ea_mode == MODE_DREG);

  // pc-relative and immediate forms sit at extended regs 2..4
  assign src_mode_ok = (ea_mode == MODE_EXT) ? (ea_reg <= EXT_IMM)
                     : !((ea_mode == MODE_AREG)
                         && (sub_size == SZ_BYTE));

  // opmodes 3 and 7 belong to the address-register form, not handled here
  assign sub_size_ok = (sub_size != SZ_NONE);
  assign sub_legal   = is_sub && sub_size_ok
                     && (sub_to_ea ? mem_alterable
                                   : src_mode_ok);
  assign scc_legal   = is_scc && data_alterable;

  assign supervisor = core_reg.psw[PSW_SUPER];
  assign trace_on   = core_reg.psw[PSW_TRACE_CTL_LOW]
                    && !core_reg.psw[PSW_TRACE_CTL_HIGH];
  // compare against the mask now held, i.e. the one the halt loaded
  assign irq_above_mask = (irq_level
                           > core_reg.psw[PSW_MASK_HI:PSW_MASK_LO]);

  assign sub_minuend    = sub_to_ea ? ea_operand : dreg_operand;
  assign sub_subtrahend = sub_to_ea ? dreg_operand : ea_operand;

  cond_eval u_cond
  (
    .sel       (opcode[11:8]),
    .n         (core_reg.psw[PSW_N]),
    .z         (core_reg.psw[PSW_Z]),
    .v         (core_reg.psw[PSW_V]),
    .c         (core_reg.psw[PSW_C]),
    .cond_true (cond_true)
  );

  sub_unit u_sub
  (
    .size       (sub_size),
    .minuend    (sub_minuend),
    .subtrahend (sub_subtrahend),
    .diff       (sub_diff),
    .flags      (sub_flags)
  );

  always_comb
  begin
    core_next = core_reg;
    // pulses last one cycle
    core_next.wb.valid = 1'b0;
    core_next.exc      = '0;
    case (core_reg.st)
      ST_RESET:
      begin
        // first cycle after release always reports the reset
        core_next.exc.rst   = 1'b1;
        core_next.st        = ST_RUN;
        core_next.fetch_en  = 1'b1;
        core_next.trace_pend = 1'b0;
      end
      ST_RUN:
      begin
        if (instr_valid)
        begin
          if (is_halt)
          begin
            if (supervisor)
            begin
              // whole word, flags included, comes from the operand
              core_next.psw            = ext_word;
              core_next.exc.pc_advance = 1'b1;
              core_next.trace_pend     = trace_on;
              core_next.fetch_en       = 1'b0;
              core_next.st             = ST_HALT;
            end
            else
            begin
              core_next.exc.priv_trap = 1'b1;
            end
          end
          else if (scc_legal)
          begin
            // flags untouched: psw is not written on this path
            core_next.wb.valid        = 1'b1;
            core_next.wb.to_ea        = (ea_mode != MODE_DREG);
            core_next.wb.data_reg_sel = ea_reg;
            core_next.wb.size         = SZ_BYTE;
            core_next.wb.data         = {24'h000000,
                                         {8{cond_true}}};
          end
          else if (sub_legal)
          begin
            core_next.wb.valid        = 1'b1;
            core_next.wb.to_ea        = sub_to_ea;
            core_next.wb.data_reg_sel = opcode[11:9];
            core_next.wb.size         = sub_size;
            core_next.wb.data         = sub_diff;
            core_next.psw[PSW_X:PSW_C] = sub_flags;
          end
          else
          begin
            // bad mode for its direction, or an opcode not handled here
            core_next.exc.illegal = 1'b1;
          end
        end
      end
      ST_HALT:
      begin
        // trace outranks a pending interrupt; both leave the halt
        if (core_reg.trace_pend)
        begin
          core_next.exc.trace  = 1'b1;
          core_next.trace_pend = 1'b0;
          core_next.fetch_en   = 1'b1;
          core_next.st         = ST_RUN;
        end
        else if (irq_above_mask)
        begin
          core_next.exc.irq       = 1'b1;
          core_next.exc.irq_level = irq_level;
          core_next.fetch_en      = 1'b1;
          core_next.st            = ST_RUN;
        end
        else
        begin
          // lower or equal requests are ignored, still halted
          core_next.fetch_en = 1'b0;
        end
      end
      default:
      begin
        core_next.st       = ST_RESET;
        core_next.fetch_en = 1'b0;
      end
    endcase
  end

  // reset leaves any state, halt included
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      core_reg.st         <= ST_RESET;
      core_reg.psw        <= PSW_RESET;
      core_reg.trace_pend <= 1'b0;
      core_reg.fetch_en   <= 1'b0;
      core_reg.wb         <= '0;
      core_reg.exc        <= '0;
    end
    else
    begin
      core_reg <= core_next;
    end
  end

  assign fetch_en             = core_reg.fetch_en;
  assign processor_state_word = core_reg.psw;
  assign wb                   = core_reg.wb;
  assign exc                  = core_reg.exc;

endmodule

/* File: verification/cshs_checker.sv */
// Purpose: port-level assertions for the decode/execute block
// Assumes: one clock, asynchronous active-low reset
// Notes: sees only the top module's ports
`timescale 1ns/10ps
module cshs_checker
  import exec_pkg::*;
(
  input wire logic        mclk,
  input wire logic        rstn,
  input wire logic        instr_valid,
  input wire logic [15:0] opcode,
  input wire logic [15:0] ext_word,
  input wire logic [31:0] ea_operand,
  input wire logic [31:0] dreg_operand,
  input wire logic [2:0]  irq_level,
  input wire logic        fetch_en,
  input wire logic [15:0] processor_state_word,
  input wire wb_t         wb,
  input wire exc_t        exc
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  logic        take;
  logic        scc;
  logic        halt;
  logic [15:0] psw;
  assign psw  = processor_state_word;
  assign take = fetch_en && instr_valid;
  assign halt = take && opcode == OP_HALT;
  assign scc  = take && opcode[15:12] == OP_SCC_LINE
                && opcode[7:6] == OP_SCC_SIZE && opcode[5:3] != MODE_AREG
                && !(opcode[5:3] == MODE_EXT && opcode[2:0] > EXT_ABS_L);
  property p_scc_true;
    scc && opcode[11:8] == 4'h0 |=> wb.valid && wb.data == 32'h000000FF;
  endproperty
  a_scc_true: assert property (p_scc_true) else $error("scc data");
  property p_scc_flags;
    scc |=> psw[4:0] == $past(psw[4:0]);
  endproperty
  a_scc_flags: assert property (p_scc_flags) else $error("scc flags");
  property p_halt_super;
    halt && psw[13] |=> psw == $past(ext_word) && exc.pc_advance && !fetch_en;
  endproperty
  a_halt_super: assert property (p_halt_super) else $error("halt");
  property p_halt_user;
    halt && !psw[13] |=> exc.priv_trap && psw == $past(psw) && fetch_en;
  endproperty
  a_halt_user: assert property (p_halt_user) else $error("user");
  property p_resume;
    $rose(fetch_en) |-> exc.rst || exc.trace || exc.irq;
  endproperty
  a_resume: assert property (p_resume) else $error("resume");
  property p_trace;
    halt && psw[15:13] == 3'h3 |-> ##2 exc.trace && fetch_en;
  endproperty
  a_trace: assert property (p_trace) else $error("trace");
  property p_irq;
    exc.irq |-> exc.irq_level == $past(irq_level)
      && $past(irq_level) > $past(psw[10:8]);
  endproperty
  a_irq: assert property (p_irq) else $error("irq level");
  property p_sub;
    take && opcode[15:12] == OP_SUB_LINE && opcode[8:3] == 6'h0 |=>
      wb.data[7:0] == $past(dreg_operand[7:0]) - $past(ea_operand[7:0])
      && psw[0] == ($past(dreg_operand[7:0]) < $past(ea_operand[7:0]))
      && psw[4] == psw[0];
  endproperty
  a_sub: assert property (p_sub) else $error("sub byte");
  // a data register is never a legal destination in the ea-minus form
  property p_sub_dst;
    take && opcode[15:12] == OP_SUB_LINE && opcode[8:6] == 3'h4
      && opcode[5:3] == MODE_DREG |=> exc.illegal && !wb.valid;
  endproperty
  a_sub_dst: assert property (p_sub_dst) else $error("sub dest");
  c_halt: cover property (halt && psw[13]);
  c_irq: cover property (exc.irq);
  c_trace: cover property (exc.trace);
endmodule

/* File: verification/fetch_model.sv */
// Purpose: instruction fetch and operand side model
// Assumes: caller waits for fetch_en unless a refusal is meant
// Notes: idle lines carry the inverse of the last value, not stale data
`timescale 1ns/10ps
module fetch_model
(
  input  wire logic   mclk,
  output logic        instr_valid,
  output logic [15:0] opcode,
  output logic [15:0] ext_word,
  output logic [31:0] ea_operand,
  output logic [31:0] dreg_operand
);
  initial
  begin
    instr_valid = 1'b0;
    opcode = 16'h0000;
    ext_word = 16'h0000;
    ea_operand = 32'h0;
    dreg_operand = 32'h0;
  end
  // one word per taking edge; operands ride with it
  task automatic issue(input logic [15:0] op, input logic [15:0] ext,
                       input logic [31:0] ea, input logic [31:0] dr);
    @(posedge mclk);
    instr_valid <= 1'b1;
    opcode <= op;
    ext_word <= ext;
    ea_operand <= ea;
    dreg_operand <= dr;
    @(posedge mclk);
    instr_valid <= 1'b0;
    opcode <= ~op;
    ext_word <= ~ext;
    ea_operand <= ~ea;
    dreg_operand <= ~dr;
  endtask
endmodule

/* File: verification/test_cond_set_halt_subtract_exec.sv */
// Purpose: self-checking bench for the decode/execute block
// Assumes: answers land on the taking edge itself
// Notes: flags are set by byte subtracts, then every selector is tried
`timescale 1ns/10ps
module test_cond_set_halt_subtract_exec;
  import exec_pkg::*;
  logic        mclk;
  logic        rstn;
  logic [2:0]  irq_level;
  logic        instr_valid;
  logic [15:0] opcode;
  logic [15:0] ext_word;
  logic [31:0] ea_operand;
  logic [31:0] dreg_operand;
  logic        fetch_en;
  logic [15:0] psw;
  wb_t         wb;
  exc_t        exc;
  int          mismatches;
  int          samples_checked;
  logic [31:0] d_t[4] = '{32'h5, 32'h0, 32'h80, 32'h3};
  logic [31:0] e_t[4] = '{32'h1, 32'h1, 32'h1, 32'h3};
  logic [7:0]  r_t[4] = '{8'h04, 8'hFF, 8'h7F, 8'h00};
  logic [4:0]  f_t[4] = '{5'h00, 5'h19, 5'h02, 5'h04};
  logic [15:0] m_t[4] = '{16'h5555, 16'hA969, 16'hA655, 16'h9599};
  logic [15:0] bad[6] = '{16'h50C8, 16'h9100, 16'h9008, 16'h913A,
                         16'h50FA, 16'h903D};
  fetch_model fm (.mclk(mclk), .instr_valid(instr_valid), .opcode(opcode),
    .ext_word(ext_word), .ea_operand(ea_operand),
    .dreg_operand(dreg_operand));
  cond_set_halt_subtract_exec dut (.mclk(mclk), .rstn(rstn),
    .instr_valid(instr_valid), .opcode(opcode), .ext_word(ext_word),
    .ea_operand(ea_operand), .dreg_operand(dreg_operand),
    .irq_level(irq_level), .fetch_en(fetch_en),
    .processor_state_word(psw), .wb(wb), .exc(exc));
  task automatic check(input logic [47:0] got, input logic [47:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish;
    if (mismatches == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // result is looked at just after the answering edge has landed
  task automatic go(input logic [15:0] op, input logic [15:0] ext,
                    input logic [31:0] ea, input logic [31:0] dr);
    fm.issue(op, ext, ea, dr);
    #1;
  endtask
  task automatic do_reset;
    @(posedge mclk);
    rstn <= 1'b0;
    repeat (2) @(posedge mclk);
    #1 check({fetch_en, psw}, {1'b0, 16'h2700});
    @(posedge mclk);
    rstn <= 1'b1;
    @(posedge mclk);
    #1 check({exc.rst, fetch_en}, 2'b11);
  endtask
  task automatic irq_at(input logic [2:0] lvl);
    @(posedge mclk);
    irq_level <= lvl;
    @(posedge mclk);
    #1;
  endtask
  initial
  begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  initial
  begin
    #100000;
    mismatches++;
    tally_and_finish;
  end
  initial
  begin
    rstn = 1'b0;
    irq_level = 3'h0;
    mismatches = 0;
    samples_checked = 0;
    do_reset;
    for (int i = 0; i < 4; i++)
    begin
      go(16'h9001, 16'h0, e_t[i], d_t[i]);
      check({wb.valid, wb.data[7:0], psw[4:0]}, {1'b1, r_t[i], f_t[i]});
      for (int s = 0; s < 16; s++)
      begin
        go({4'h5, s[3:0], 8'hC0}, 16'h0, 32'h0, 32'h0);
        check({wb.valid, wb.data, psw[4:0]},
              {1'b1, 24'h0, {8{m_t[i][s]}}, f_t[i]});
      end
    end
    go(16'h56F9, 16'h0, 32'h0, 32'h0);
    check({wb.valid, wb.to_ea, wb.size, wb.data, psw[4:0]},
          {2'b11, SZ_BYTE, 32'h0, 5'h04});
    go(16'h9249, 16'h0, 32'h1, 32'h12348000);
    check({wb.valid, wb.to_ea, wb.data_reg_sel, wb.size, wb.data, psw[4:0]},
          {2'b10, 3'h1, SZ_WORD, 32'h12347FFF, 5'h02});
    go(16'h9790, 16'h0, 32'h1, 32'h2);
    check({wb.to_ea, wb.data_reg_sel, wb.size, wb.data, psw[4:0]},
          {1'b1, 3'h3, SZ_LONG, 32'hFFFFFFFF, 5'h19});
    for (int b = 0; b < 6; b++)
    begin
      go(bad[b], 16'h0, 32'h1, 32'h2);
      check({exc.illegal, wb.valid, psw[4:0]}, {2'b10, 5'h19});
    end
    go(OP_HALT, 16'h6300, 32'h0, 32'h0);
    check({psw, fetch_en, exc.pc_advance}, {16'h6300, 2'b01});
    irq_at(3'h3);
    go(16'h50C0, 16'h0, 32'h0, 32'h0);
    repeat (3) @(posedge mclk);
    #1 check({fetch_en, wb.valid, exc.irq}, 3'h0);
    irq_at(3'h4);
    check({exc.irq, exc.irq_level, fetch_en}, {1'b1, 3'h4, 1'b1});
    irq_at(3'h0);
    go(OP_HALT, 16'h2000, 32'h0, 32'h0);
    check({psw, fetch_en}, {16'h2000, 1'b0});
    @(posedge mclk);
    #1 check({exc.trace, fetch_en}, 2'b11);
    go(OP_HALT, 16'h2700, 32'h0, 32'h0);
    irq_at(3'h7);
    repeat (3) @(posedge mclk);
    #1 check({fetch_en, exc.irq}, 2'b00);
    do_reset;
    irq_at(3'h0);
    go(OP_HALT, 16'h0000, 32'h0, 32'h0);
    irq_at(3'h1);
    check({exc.irq, fetch_en}, 2'b11);
    irq_at(3'h0);
    go(OP_HALT, 16'h2700, 32'h0, 32'h0);
    check({exc.priv_trap, psw, fetch_en}, {1'b1, 16'h0000, 1'b1});
    tally_and_finish;
  end
endmodule
bind cond_set_halt_subtract_exec cshs_checker chk (.mclk(mclk),
  .rstn(rstn), .instr_valid(instr_valid), .opcode(opcode),
  .ext_word(ext_word), .ea_operand(ea_operand),
  .dreg_operand(dreg_operand), .irq_level(irq_level),
  .fetch_en(fetch_en), .processor_state_word(processor_state_word),
  .wb(wb), .exc(exc));
